//--- testbench/upm_match_unit_bench.sv
// upm_match_unit_bench.sv: self-checking bench for the packet match unit
// assumes upm_src as byte source; rx config stays idle unless a test sets it
`timescale 1ns/1ps
`default_nettype none
`include "upm_consts.svh"
module upm_match_unit_bench;
    logic               clock_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               hold_i = 1'b0;
    logic               in_valid;
    logic               in_ready;
    upm_pkg::upm_word_t in_word;
    upm_pkg::upm_word_t w;
    upm_pkg::upm_cfg_t  cfg_tx = '0;
    upm_pkg::upm_cfg_t  cfg_rx;
    upm_pkg::upm_cfg_t  nev;
    logic               pat_wr = 1'b0;
    logic               pat_dir = 1'b0;
    logic [9:0]         pat_addr = '0;
    logic [7:0]         pat_data = '0;
    logic [7:0]         pat_mask = '0;
    logic [1:0]         match;
    logic [1:0]         hdr_pend;
    int                 fail_count = 0;
    int                 checks = 0;
    int                 hit_tx = 0;
    int                 hit_rx = 0;
    // pass table per crc selector, indexed by {first ok, second ok}
    logic [3:0]         crc_tab [8] = '{4'hf, 4'hc, 4'ha, 4'h8, 4'h7, 4'h3, 4'h5, 4'h1};

    always #12.5 clock_i = ~clock_i;

    upm_src upm_src_i (.clock_i(clock_i), .ready_i(in_ready), .valid_o(in_valid), .word_o(in_word));

    upm_match_unit #(.PAT_DEPTH(1024), .FIFO_DEPTH(32)) upm_match_unit_i (
        .clock_i(clock_i), .rst_i(rst_i), .in_valid_i(in_valid), .in_ready_o(in_ready),
        .in_word_i(in_word), .hold_i(hold_i), .cfg_tx_i(cfg_tx), .cfg_rx_i(cfg_rx),
        .pat_wr_i(pat_wr), .pat_dir_i(pat_dir), .pat_addr_i(pat_addr), .pat_data_i(pat_data),
        .pat_mask_i(pat_mask), .match_o(match), .hdr_pend_o(hdr_pend));

    // pulses sampled mid-cycle; a pulse longer than one cycle counts once per cycle
    always @(negedge clock_i) begin
        if (match[0] === 1'b1) hit_tx++;
        if (match[1] === 1'b1) hit_rx++;
    end

    task automatic final_report();
        if (fail_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: saw %0h, expected %0h", $time, seen, exp);
        end
    endtask

    function automatic int mod_hit(input int m, input logic t, input logic p, input logic q);
        case (m)
            0: return t & p & q;
            1: return t & !(p & q);
            2: return !(t & p & q);
            default: return t & !p & q;
        endcase
    endfunction

    task automatic put(input logic sop, input logic eop, input logic [7:0] d);
        upm_pkg::upm_word_t x;
        x = w;
        x.sop = sop;
        x.eop = eop;
        x.data = d;
        upm_src_i.q.push_back(x);
    endtask

    task automatic one(input logic [3:0] c);
        w.cls = c;
        put(1'b1, 1'b1, 8'h00);
    endtask

    // n bytes, most significant first
    task automatic seq(input int n, input logic [31:0] d);
        for (int i = 0; i < n; i++) put(i == 0, i == n - 1, d[8 * (n - 1 - i) +: 8]);
    endtask

    task automatic expect_hits(input int et, input int er);
        for (int i = 0; i < 400 && (upm_src_i.q.size() > 0 || in_valid); i++) @(posedge clock_i);
        repeat (6) @(posedge clock_i);
        check(hit_tx, et);
        check(hit_rx, er);
        hit_tx = 0;
        hit_rx = 0;
    endtask

    task automatic cfg(input upm_pkg::upm_cfg_t t, input upm_pkg::upm_cfg_t r);
        @(posedge clock_i);
        cfg_tx <= t;
        cfg_rx <= r;
        @(posedge clock_i);
    endtask

    task automatic wpat(input logic dir, input logic [9:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge clock_i);
        pat_wr <= 1'b1;
        pat_dir <= dir;
        pat_addr <= a;
        pat_data <= d;
        pat_mask <= m;
        @(posedge clock_i);
        pat_wr <= 1'b0;
    endtask

    task automatic t_class();
        upm_pkg::upm_cfg_t c;
        c = '0;
        for (int k = 0; k < 9; k++) begin
            if (k == 3 || k == 6) continue;
            c.cls = k[3:0];
            cfg(c, nev);
            one(k[3:0]);
            one(k == 8 ? 4'h0 : k[3:0] + 4'h1);
            w.dir = 1'b1;
            one(k[3:0]);
            w.dir = 1'b0;
            expect_hits(1, 0);
        end
    endtask

    task automatic t_crc();
        upm_pkg::upm_cfg_t c;
        int e;
        c = '0;
        for (int k = 0; k < 3; k++)
            for (int s = 0; s < 8; s++) begin
                c.cls = k[3:0];
                c.err_sel = s[2:0];
                cfg(c, nev);
                e = 0;
                for (int j = 0; j < 4; j++) begin
                    w.crc1_ok = j[1];
                    w.crc2_ok = j[0];
                    one(k[3:0]);
                    e += crc_tab[s][j];
                end
                expect_hits(e, 0);
            end
    endtask

    task automatic t_err();
        upm_pkg::upm_cfg_t c;
        int e;
        c = '0;
        c.cls = `UPM_CLS_ERROR;
        for (int s = 1; s < 8; s++) begin
            c.err_sel = s[2:0];
            cfg(c, nev);
            e = 0;
            for (int j = 0; j < 8; j++) begin
                w.errs = j[2:0];
                one(`UPM_CLS_ERROR);
                e += ((s & j) != 0);
            end
            expect_hits(e, 0);
        end
        w.crc1_ok = 1'b0;
        w.crc2_ok = 1'b0;
        for (int k = 4; k < 9; k++) begin
            if (k == 6) continue;
            c.cls = k[3:0];
            cfg(c, nev);
            one(k[3:0]);
            expect_hits(1, 0);
        end
        w.errs = 3'h0;
        w.crc1_ok = 1'b1;
        w.crc2_ok = 1'b1;
    endtask

    task automatic t_pat();
        upm_pkg::upm_cfg_t c;
        c = '0;
        w.cls = `UPM_CLS_LINK_CMD;
        c.pat_len = 11'h003;
        wpat(1'b0, 10'h000, 8'ha5, 8'hff);
        wpat(1'b0, 10'h001, 8'h3c, 8'h00);
        wpat(1'b0, 10'h002, 8'h0f, 8'h01);
        wpat(1'b1, 10'h000, 8'h5a, 8'hff);
        cfg(c, nev);
        seq(3, 32'ha5000f);
        seq(3, 32'ha53c0e);
        seq(3, 32'ha43c0f);
        seq(2, 32'ha53c);
        seq(4, 32'ha5110f77);
        expect_hits(2, 0);
        c.pat_len = 11'h000;
        cfg(c, nev);
        seq(2, 32'h1234);
        expect_hits(1, 0);
        c.pat_len = 11'h001;
        cfg(c, c);
        seq(1, 32'ha5);
        seq(1, 32'h5a);
        w.dir = 1'b1;
        seq(1, 32'ha5);
        seq(1, 32'h5a);
        w.dir = 1'b0;
        expect_hits(1, 1);
    endtask

    task automatic t_prop();
        upm_pkg::upm_cfg_t c;
        int fb [5] = '{48, 40, 32, 16, 4};
        c = '0;
        c.prop_en = 1'b1;
        c.pmode = '{`UPM_CMP_EQ, `UPM_CMP_EQ, `UPM_CMP_EQ, `UPM_CMP_EQ, `UPM_CMP_GE};
        c.pval = '{2'h2, 8'hff, 8'h80, 16'h8001, 16'h0010};
        cfg(c, nev);
        for (int j = 0; j < 6; j++) begin
            w.props = c.pval ^ (j == 0 ? 50'h0 : 50'h1 << fb[j - 1]);
            one(`UPM_CLS_LINK_CMD);
        end
        w.props.len = 16'hffff;
        one(`UPM_CLS_LINK_CMD);
        expect_hits(2, 0);
        c.pmode.len = `UPM_CMP_LE;
        cfg(c, nev);
        w.props = c.pval;
        one(`UPM_CLS_LINK_CMD);
        w.props.len = 16'h0011;
        one(`UPM_CLS_LINK_CMD);
        w.props.len = 16'h0000;
        one(`UPM_CLS_LINK_CMD);
        expect_hits(2, 0);
        c.prop_en = 1'b0;
        cfg(c, nev);
        for (int j = 0; j < 5; j++) begin
            w.props = c.pval ^ (50'h1 << fb[j]);
            one(`UPM_CLS_LINK_CMD);
        end
        expect_hits(5, 0);
    endtask

    task automatic t_mod();
        upm_pkg::upm_cfg_t c;
        int e;
        c = '0;
        c.pat_len = 11'h001;
        c.prop_en = 1'b1;
        c.pmode.ep = `UPM_CMP_EQ;
        c.pval.ep = 8'h11;
        w.props = '0;
        for (int m = 0; m < 4; m++) begin
            c.modifier = m[1:0];
            cfg(c, nev);
            e = 0;
            for (int j = 0; j < 8; j++) begin
                w.props.ep = j[0] ? 8'h11 : 8'h22;
                w.cls = j[2] ? `UPM_CLS_LINK_CMD : `UPM_CLS_TRAIN_SEQ;
                put(1'b1, 1'b1, j[1] ? 8'ha5 : 8'h5a);
                e += mod_hit(m, j[2], j[1], j[0]);
            end
            expect_hits(e, 0);
        end
        // empty pattern stays true, so the pattern-negating form cannot fire
        c.pat_len = 11'h000;
        cfg(c, nev);
        w.props.ep = 8'h11;
        one(`UPM_CLS_LINK_CMD);
        expect_hits(0, 0);
        c.modifier = `UPM_MOD_ALL;
        cfg(c, nev);
        one(`UPM_CLS_LINK_CMD);
        expect_hits(1, 0);
    endtask

    task automatic t_qual();
        upm_pkg::upm_cfg_t c;
        c = '0;
        c.cls = `UPM_CLS_QUAL;
        cfg(c, nev);
        one(`UPM_CLS_HEADER);
        expect_hits(0, 0);
        check(hdr_pend, 2'b01);
        one(`UPM_CLS_PAYLOAD);
        expect_hits(1, 0);
        check(hdr_pend, 2'b00);
        one(`UPM_CLS_PAYLOAD);
        one(`UPM_CLS_HEADER);
        one(`UPM_CLS_LINK_CMD);
        one(`UPM_CLS_PAYLOAD);
        expect_hits(0, 0);
        // header properties and payload slots decide a qualified unit
        c.prop_en = 1'b1;
        c.pmode.ep = `UPM_CMP_EQ;
        c.pval.ep = 8'h33;
        c.err_sel = `UPM_CRC_2_PASS;
        cfg(c, nev);
        for (int j = 0; j < 3; j++) begin
            w.props.ep = (j == 2) ? 8'h00 : 8'h33;
            one(`UPM_CLS_HEADER);
            w.props.ep = (j == 2) ? 8'h33 : 8'h00;
            w.crc2_ok = (j != 0);
            one(`UPM_CLS_PAYLOAD);
        end
        w.crc2_ok = 1'b1;
        expect_hits(1, 0);
    endtask

    task automatic t_rep_fifo();
        upm_pkg::upm_cfg_t c;
        int t0;
        c = '0;
        c.repeat_cnt = 16'h0002;
        cfg(c, nev);
        repeat (2) one(`UPM_CLS_LINK_CMD);
        expect_hits(0, 0);
        one(`UPM_CLS_LINK_CMD);
        expect_hits(1, 0);
        repeat (3) one(`UPM_CLS_LINK_CMD);
        expect_hits(1, 0);
        cfg('0, nev);
        hold_i <= 1'b1;
        t0 = upm_src_i.taken;
        repeat (40) one(`UPM_CLS_LINK_CMD);
        for (int i = 0; i < 200 && upm_src_i.taken - t0 < 32; i++) @(posedge clock_i);
        repeat (4) @(posedge clock_i);
        check(in_ready, 1'b0);
        check(upm_src_i.taken - t0, 32);
        check(hit_tx, 0);
        hold_i <= 1'b0;
        repeat (60) @(posedge clock_i);
        expect_hits(40, 0);
    endtask

    initial begin
        #500000;
        fail_count++;
        final_report();
    end

    initial begin
        w = '0;
        w.crc1_ok = 1'b1;
        w.crc2_ok = 1'b1;
        nev = '0;
        nev.cls = `UPM_CLS_ERROR;
        cfg_rx = nev;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check(match, 2'b00);
        check(hdr_pend, 2'b00);
        check(in_ready, 1'b1);
        t_class();
        t_crc();
        t_err();
        t_pat();
        t_prop();
        t_mod();
        t_qual();
        t_rep_fifo();
        final_report();
    end
endmodule // upm_match_unit_bench
`default_nettype wire

//--- testbench/upm_src.sv
// upm_src.sv: behavioural capture front end offering decoded bytes
// assumes the match unit's valid/ready byte stream on one clock
`timescale 1ns/1ps
`default_nettype none
module upm_src (
    // clock
    input  wire logic          clock_i,
    // byte stream
    input  wire logic          ready_i,
    output logic               valid_o,
    output upm_pkg::upm_word_t word_o
);
    upm_pkg::upm_word_t q[$];
    int                 taken;
    initial begin
        valid_o = 1'b0;
        word_o = '0;
        taken = 0;
    end
    // a byte holds until taken; idle data toggles so a stale byte cannot pass
    always @(posedge clock_i) begin
        if (valid_o && ready_i) begin
            void'(q.pop_front());
            taken++;
        end
        if (q.size() > 0) begin
            valid_o <= 1'b1;
            word_o <= q[0];
        end else begin
            valid_o <= 1'b0;
            word_o <= ~word_o;
        end
    end
endmodule // upm_src
`default_nettype wire

//--- verilog/upm_consts.svh
// upm_consts.svh: encodings, field positions and sizes of the packet match unit
// assumes inclusion by the design and bench files, definitions only
`ifndef UPM_CONSTS_SVH
`define UPM_CONSTS_SVH
`define UPM_CLS_LINK_CMD  4'h0
`define UPM_CLS_HEADER    4'h1
`define UPM_CLS_PAYLOAD   4'h2
`define UPM_CLS_QUAL      4'h3
`define UPM_CLS_TRAIN_SEQ 4'h4
`define UPM_CLS_TSEQ      4'h5
`define UPM_CLS_ERROR     4'h6
`define UPM_CLS_TX_START  4'h7
`define UPM_CLS_TX_STOP   4'h8
`define UPM_CRC_IGNORE    3'h0
`define UPM_CRC_1_PASS    3'h1
`define UPM_CRC_2_PASS    3'h2
`define UPM_CRC_BOTH_PASS 3'h3
`define UPM_CRC_ANY_FAIL  3'h4
`define UPM_CRC_1_FAIL    3'h5
`define UPM_CRC_2_FAIL    3'h6
`define UPM_CRC_BOTH_FAIL 3'h7
`define UPM_ERR_CRC_BIT   0
`define UPM_ERR_FRM_BIT   1
`define UPM_ERR_UNK_BIT   2
`define UPM_CMP_OFF       2'h0
`define UPM_CMP_EQ        2'h1
`define UPM_CMP_LE        2'h2
`define UPM_CMP_GE        2'h3
`define UPM_MOD_ALL       2'h0
`define UPM_MOD_NOT_PP    2'h1
`define UPM_MOD_NOT_ALL   2'h2
`define UPM_MOD_NOT_PAT   2'h3
`define UPM_PAT_DEPTH     1024
`define UPM_FIFO_DEPTH    32
`define UPM_IDX_MAX       11'h7ff
`endif

//--- verilog/upm_match_unit.sv
// upm_match_unit.sv: input fifo and two-direction packet match unit
// assumes a same-clock capture front end delivering decoded bytes
`timescale 1ns/1ps
`default_nettype none
`include "upm_consts.svh"

module upm_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = `UPM_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // fill side
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    // drain side
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          wr;
    logic          rd;

    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem[rp_r];
    assign wr = in_valid_i && in_ready_o;
    assign rd = out_valid_o && out_ready_i;

    always_ff @(posedge clock_i) begin
        if (wr) begin
            mem[wp_r] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (wr) begin
                wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (rd) begin
                rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
        end
    end

    fifo_bound_a: assert property (@(posedge clock_i) disable iff (rst_i)
        cnt_r <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");

    fifo_full_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (cnt_r == (AW+1)'(DEPTH)) && !rd |=> !in_ready_o)
        else $error("fifo took data while full");
endmodule // upm_fifo

module upm_match_unit #(
    parameter int PAT_DEPTH  = `UPM_PAT_DEPTH,
    parameter int FIFO_DEPTH = `UPM_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                clock_i,
    input  wire logic                rst_i,
    // decoded packet bytes
    input  wire logic                in_valid_i,
    output logic                     in_ready_o,
    input  wire upm_pkg::upm_word_t  in_word_i,
    // trigger sequencer hold
    input  wire logic                hold_i,
    // per-direction configuration
    input  wire upm_pkg::upm_cfg_t   cfg_tx_i,
    input  wire upm_pkg::upm_cfg_t   cfg_rx_i,
    // pattern and mask load
    input  wire logic                pat_wr_i,
    input  wire logic                pat_dir_i,
    input  wire logic [9:0]          pat_addr_i,
    input  wire logic [7:0]          pat_data_i,
    input  wire logic [7:0]          pat_mask_i,
    // match result and status
    output logic [1:0]               match_o,
    output logic [1:0]               hdr_pend_o
);
    localparam int WW = $bits(upm_pkg::upm_word_t);

    logic [7:0] pat_mem [2][PAT_DEPTH];
    logic [7:0] msk_mem [2][PAT_DEPTH];

    upm_pkg::upm_qstate_t qst_r [2];
    upm_pkg::upm_props_t  hprops_r [2];
    logic [10:0]          idx_r [2];
    logic [1:0]           miss_r;
    logic [15:0]          rep_r [2];

    upm_pkg::upm_word_t w;
    upm_pkg::upm_cfg_t  cfg;
    upm_pkg::upm_props_t pv;
    logic          f_valid;
    logic [WW-1:0] f_data;
    logic          take;
    logic          d;
    logic          cont;
    logic [10:0]   pos;
    logic          byte_bad;
    logic          miss_now;
    logic          pat_ok;
    logic          cls_ok;
    logic          crc_ok;
    logic          type_ok;
    logic          prop_ok;
    logic          hit;
    logic          fire;

    function automatic logic crc_pass(input logic [2:0] sel,
                                      input logic c1,
                                      input logic c2);
        case (sel)
            `UPM_CRC_IGNORE:    crc_pass = 1'b1;
            `UPM_CRC_1_PASS:    crc_pass = c1;
            `UPM_CRC_2_PASS:    crc_pass = c2;
            `UPM_CRC_BOTH_PASS: crc_pass = c1 && c2;
            `UPM_CRC_ANY_FAIL:  crc_pass = !c1 || !c2;
            `UPM_CRC_1_FAIL:    crc_pass = !c1;
            `UPM_CRC_2_FAIL:    crc_pass = !c2;
            default:            crc_pass = !c1 && !c2;
        endcase
    endfunction

    function automatic logic prop_cmp(input logic [1:0]  mode,
                                      input logic [15:0] val,
                                      input logic [15:0] ref_v);
        case (mode)
            `UPM_CMP_OFF: prop_cmp = 1'b1;
            `UPM_CMP_EQ:  prop_cmp = (val == ref_v);
            `UPM_CMP_LE:  prop_cmp = (val <= ref_v);
            default:      prop_cmp = (val >= ref_v);
        endcase
    endfunction

    upm_fifo #(
        .W     (WW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .in_valid_i  (in_valid_i),
        .in_ready_o  (in_ready_o),
        .in_data_i   (WW'(in_word_i)),
        .out_valid_o (f_valid),
        .out_ready_i (!hold_i),
        .out_data_o  (f_data)
    );

    assign w    = upm_pkg::upm_word_t'(f_data);
    assign take = f_valid && !hold_i;
    assign d    = w.dir;
    assign cfg  = d ? cfg_rx_i : cfg_tx_i;

    // payload that follows an armed header continues the same unit
    assign cont = (qst_r[d] == upm_pkg::Q_HDR) && (w.cls == `UPM_CLS_PAYLOAD);
    assign pos  = (w.sop && !cont) ? 11'h000 : idx_r[d];

    always_comb begin
        byte_bad = 1'b0;
        if (pos < cfg.pat_len && msk_mem[d][pos[9:0]] != 8'h00) begin
            byte_bad = (w.data != pat_mem[d][pos[9:0]]);
        end
    end

    assign miss_now = ((w.sop && !cont) ? 1'b0 : miss_r[d]) | byte_bad;
    // a packet shorter than the pattern cannot match it
    assign pat_ok = (cfg.pat_len == 11'h000)
                 || (!miss_now && (pos + 11'h001) >= cfg.pat_len);

    always_comb begin
        case (cfg.cls)
            `UPM_CLS_QUAL: begin
                cls_ok = cont;
                crc_ok = crc_pass(cfg.err_sel, w.crc1_ok, w.crc2_ok);
            end
            `UPM_CLS_ERROR: begin
                cls_ok = (w.cls == `UPM_CLS_ERROR);
                crc_ok = |(cfg.err_sel & w.errs);
            end
            `UPM_CLS_LINK_CMD,
            `UPM_CLS_HEADER,
            `UPM_CLS_PAYLOAD: begin
                cls_ok = (w.cls == cfg.cls);
                // slots already mapped by the front end per class
                crc_ok = crc_pass(cfg.err_sel, w.crc1_ok, w.crc2_ok);
            end
            default: begin
                cls_ok = (w.cls == cfg.cls);
                crc_ok = 1'b1;
            end
        endcase
    end

    assign type_ok = cls_ok && crc_ok;
    assign pv      = cont ? hprops_r[d] : w.props;

    assign prop_ok = !cfg.prop_en
        || (prop_cmp(cfg.pmode.src, {14'h0000, pv.src}, {14'h0000, cfg.pval.src})
         && prop_cmp(cfg.pmode.ep, {8'h00, pv.ep}, {8'h00, cfg.pval.ep})
         && prop_cmp(cfg.pmode.dev, {8'h00, pv.dev}, {8'h00, cfg.pval.dev})
         && prop_cmp(cfg.pmode.sid, pv.sid, cfg.pval.sid)
         && prop_cmp(cfg.pmode.len, pv.len, cfg.pval.len));

    always_comb begin
        case (cfg.modifier)
            `UPM_MOD_ALL:     hit = type_ok && pat_ok && prop_ok;
            `UPM_MOD_NOT_PP:  hit = type_ok && !(pat_ok && prop_ok);
            `UPM_MOD_NOT_ALL: hit = !(type_ok && pat_ok && prop_ok);
            default:          hit = type_ok && !pat_ok && prop_ok;
        endcase
    end

    assign fire = take && w.eop && hit && (rep_r[d] == cfg.repeat_cnt);

    // pattern storage, one region per direction
    always_ff @(posedge clock_i) begin
        if (pat_wr_i) begin
            pat_mem[pat_dir_i][pat_addr_i] <= pat_data_i;
            msk_mem[pat_dir_i][pat_addr_i] <= pat_mask_i;
        end
    end

    // byte position and mismatch tracking
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < 2; i++) begin
                idx_r[i] <= 11'h000;
            end
            miss_r <= 2'b00;
        end else if (take) begin
            idx_r[d]  <= (pos == `UPM_IDX_MAX) ? pos : pos + 11'h001;
            miss_r[d] <= miss_now;
        end
    end

    // header arming for the qualified class
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < 2; i++) begin
                qst_r[i]    <= upm_pkg::Q_IDLE;
                hprops_r[i] <= '0;
            end
        end else if (take && w.eop) begin
            case (qst_r[d])
                upm_pkg::Q_IDLE,
                upm_pkg::Q_HDR: begin
                    if (cfg.cls == `UPM_CLS_QUAL && w.cls == `UPM_CLS_HEADER) begin
                        qst_r[d]    <= upm_pkg::Q_HDR;
                        hprops_r[d] <= w.props;
                    end else begin
                        qst_r[d] <= upm_pkg::Q_IDLE;
                    end
                end
                default: qst_r[d] <= upm_pkg::Q_IDLE;
            endcase
        end
    end

    // repeated match counting
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            for (int i = 0; i < 2; i++) begin
                rep_r[i] <= 16'h0000;
            end
        end else if (take && w.eop && hit) begin
            rep_r[d] <= fire ? 16'h0000 : rep_r[d] + 16'h0001;
        end
    end

    // match pulse, one cycle after the packet end
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            match_o <= 2'b00;
        end else begin
            match_o <= 2'b00;
            if (fire) begin
                match_o[d] <= 1'b1;
            end
        end
    end

    assign hdr_pend_o = {qst_r[1] == upm_pkg::Q_HDR, qst_r[0] == upm_pkg::Q_HDR};

    match_at_end_a: assert property (@(posedge clock_i) disable iff (rst_i)
        match_o != 2'b00 |-> $past(take) && $past(w.eop))
        else $error("match pulse without packet end");

    match_dir_a: assert property (@(posedge clock_i) disable iff (rst_i)
        match_o[1] |-> $past(d) && !match_o[0])
        else $error("match on wrong direction");

    repeat_gate_a: assert property (@(posedge clock_i) disable iff (rst_i)
        match_o[0] |-> $past(rep_r[0]) == $past(cfg_tx_i.repeat_cnt))
        else $error("match before repeat count");

    not_all_a: assert property (@(posedge clock_i) disable iff (rst_i)
        take && w.eop && cfg.modifier == `UPM_MOD_NOT_ALL && type_ok && pat_ok && prop_ok
        |=> match_o == 2'b00)
        else $error("negated match fired");

    empty_pattern_a: assert property (@(posedge clock_i) disable iff (rst_i)
        take && w.eop && cfg.pat_len == 11'h000 && cfg.modifier == `UPM_MOD_NOT_PAT
        |=> match_o == 2'b00)
        else $error("empty pattern treated as false");

    crc_ignored_a: assert property (@(posedge clock_i) disable iff (rst_i)
        take && w.eop && cfg.cls == `UPM_CLS_TSEQ && w.cls == `UPM_CLS_TSEQ
        && cfg.pat_len == 11'h000 && !cfg.prop_en && cfg.modifier == `UPM_MOD_ALL
        && cfg.repeat_cnt == 16'h0000 |=> match_o != 2'b00)
        else $error("class match lost");

    qual_unit_a: assert property (@(posedge clock_i) disable iff (rst_i)
        match_o[0] && $past(cfg_tx_i.cls) == `UPM_CLS_QUAL
        && $past(cfg_tx_i.modifier) == `UPM_MOD_ALL |-> $past(cont))
        else $error("qualified match without header");

    masked_byte_a: assert property (@(posedge clock_i) disable iff (rst_i)
        take && byte_bad && !w.eop && !d |=> miss_r[0])
        else $error("masked byte mismatch lost");
endmodule // upm_match_unit

`default_nettype wire

//--- verilog/upm_pkg.sv
// upm_pkg.sv: types shared by the packet match unit
// assumes upm_consts.svh for the encodings carried in these fields
package upm_pkg;

    typedef enum logic [1:0] {
        Q_IDLE = 2'b01,
        Q_HDR  = 2'b10
    } upm_qstate_t;

    typedef struct packed {
        logic [1:0]  src;
        logic [7:0]  ep;
        logic [7:0]  dev;
        logic [15:0] sid;
        logic [15:0] len;
    } upm_props_t;

    typedef struct packed {
        logic [1:0] src;
        logic [1:0] ep;
        logic [1:0] dev;
        logic [1:0] sid;
        logic [1:0] len;
    } upm_pmode_t;

    typedef struct packed {
        logic [3:0]  cls;
        logic [10:0] pat_len;
        logic [2:0]  err_sel;
        logic        prop_en;
        upm_pmode_t  pmode;
        upm_props_t  pval;
        logic [1:0]  modifier;
        logic [15:0] repeat_cnt;
    } upm_cfg_t;

    // one captured byte; status fields are read on the eop byte
    typedef struct packed {
        logic       dir;
        logic       sop;
        logic       eop;
        logic [7:0] data;
        logic [3:0] cls;
        logic       crc1_ok;
        logic       crc2_ok;
        logic [2:0] errs;
        upm_props_t props;
    } upm_word_t;

endpackage
